// ===== hdl/mrcfg_cwl_dec.sv
// Write data latency code decode.
`timescale 1ns/100ps
module mrcfg_cwl_dec
(
  // Code in.
  input wire logic [2:0] i_code,
  input wire logic i_pre2,
  // Decoded cycles.
  output logic [4:0] o_cycles,
  output logic o_valid
);
  // Whole cycles only; two-clock preamble blocks the low codes.
  always_comb
  begin
    o_valid = 1'b1;
    unique case (i_code)
      3'h0: o_cycles = 5'h09;
      3'h1: o_cycles = 5'h0A;
      3'h2: o_cycles = 5'h0B;
      3'h3: o_cycles = 5'h0C;
      3'h4: o_cycles = 5'h0E;
      3'h5: o_cycles = 5'h10;
      3'h6: o_cycles = 5'h12;
      3'h7: o_cycles = 5'h14;
    endcase
    if (i_pre2 && !i_code[2])
    begin
      o_valid = 1'b0;
    end
  end
endmodule

// ===== hdl/mrcfg_defines.svh
// Constants for the mode register 2/3 capture and decode block.
`ifndef MRCFG_DEFINES_SVH
`define MRCFG_DEFINES_SVH
`define MRCFG_SEL_LSB 18
`define MRCFG_SEL_MR2 3'h2
`define MRCFG_SEL_MR3 3'h3
`define MRCFG_MR_W 22
`define MRCFG_MR2_RST 22'h000000
`define MRCFG_MR3_RST 22'h000000
`define MRCFG_CRC_UI 4'hA
`define MRCFG_STD_UI 4'h8
`define MRCFG_WCL_BASE 3'h4
`endif

// ===== hdl/mrcfg_pkg.sv
// Types shared by the mode register decode block.
package mrcfg_pkg;
  typedef struct packed {
    logic [2:0] odt_wr;
    logic [1:0] sr_temp;
    logic [2:0] cwl_code;
  } mrcfg_mr2_t;
  typedef struct packed {
    logic [1:0] mpr_fmt;
    logic [1:0] wcl_code;
    logic [2:0] fgr;
    logic temp_sense;
    logic per_dev;
    logic gear_down;
    logic mpr_en;
    logic [1:0] mpr_page;
  } mrcfg_mr3_t;
  typedef struct packed {
    logic [4:0] write_data_latency;
    logic [6:0] total_write_latency;
    logic [2:0] crc_mask_write_cmd_latency;
    logic [3:0] burst_ui;
    logic [2:0] termination;
    logic lat_valid;
  } mrcfg_wr_t;
endpackage

// ===== hdl/mrcfg_top.sv
// Mode register 2/3 capture, shadow and decode.
// Notes on behaviour
// - One-clock preamble codes 101,110,111 give 16,18,20 cycles.
// - Two-clock preamble: codes 000-011 invalid; 100-111 give 14..20.
// - Write data latency comes from register 2 bits 5:3.
// - All latencies are whole clock cycles.
// - Total write latency is additive plus parity plus write data latency.
// - Write termination applies during writes when enabled.
// - Write leveling forces nominal termination only.
// - CRC enabled stretches bursts from eight to ten unit intervals.
// - Bits 20:18 select target register; 011 picks register 3.
// - Register 3 bits 12:11 choose readout format.
// - Register 3 bits 10:9 give 4,5,6,7 clock extra latency.
// - Register 3 bits 8:6 choose refresh granularity.
// - Register 3 bit 5 enables temperature status update.
// - Register 3 bit 4 enables per-device addressability.
// - Register 3 bit 3 selects gear-down ratio.
// - Register 3 bit 2 routes reads from readout register.
// - Register 3 bits 1:0 select readout page.
// - Register 2 bits 7:6 select self-refresh temperature range.
// - Write termination codes 000..100 valid, rest reserved.
// - With readout enabled, reads are redirected.
`timescale 1ns/100ps
`include "mrcfg_defines.svh"
module mrcfg_top
#(
  parameter int MR_W = `MRCFG_MR_W
)
(
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Command and address bus.
  input wire logic i_cmd_valid,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [MR_W-1:0] i_addr,
  // Operating context.
  input wire logic i_pre2,
  input wire logic i_write_active,
  input wire logic i_wr_level,
  input wire logic i_read_cmd,
  input wire logic i_crc_dm_en,
  input wire logic [4:0] i_additive_latency,
  input wire logic [4:0] i_parity_latency,
  // Decoded settings.
  output mrcfg_pkg::mrcfg_wr_t o_wr,
  output logic o_wr_odt_dyn,
  output logic [1:0] o_self_refresh_temp_range,
  output logic o_crc_en,
  output mrcfg_pkg::mrcfg_mr3_t o_mr3,
  output logic o_fgr_reserved,
  output logic o_odt_reserved,
  output logic o_read_redirect
);
  // ********************************************************
  // Shadow registers
  // ********************************************************
  logic [MR_W-1:0] mr2_q, mr2_d, mr3_q, mr3_d;
  logic mrs_hit;
  logic [2:0] sel;

  // Only a strobe-low set hits; the select picks one shadow.
  always_comb
  begin
    mrs_hit = i_cmd_valid && !i_ras_n && !i_cas_n && !i_we_n;
    sel = i_addr[`MRCFG_SEL_LSB+2:`MRCFG_SEL_LSB];
    mr2_d = mr2_q;
    mr3_d = mr3_q;
    if (mrs_hit && sel == `MRCFG_SEL_MR2)
    begin
      mr2_d = i_addr;
    end
    if (mrs_hit && sel == `MRCFG_SEL_MR3)
    begin
      mr3_d = i_addr;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      mr2_q <= `MRCFG_MR2_RST;
      mr3_q <= `MRCFG_MR3_RST;
    end
    else
    begin
      mr2_q <= mr2_d;
      mr3_q <= mr3_d;
    end
  end

  // ********************************************************
  // Decode
  // ********************************************************
  logic [4:0] cwl_cyc;
  logic cwl_ok;

  mrcfg_cwl_dec u_cwl
  (
    .i_code(mr2_q[5:3]),
    .i_pre2(i_pre2),
    .o_cycles(cwl_cyc),
    .o_valid(cwl_ok)
  );

  mrcfg_pkg::mrcfg_wr_t wr_d;
  mrcfg_pkg::mrcfg_mr3_t mr3f_d;
  logic dyn_d, fgr_rsv_d, odt_rsv_d, redir_d;

  // Outputs are registered so downstream timing sees flop outputs only.
  always_comb
  begin
    wr_d.write_data_latency = cwl_cyc;
    wr_d.lat_valid = cwl_ok;
    wr_d.total_write_latency = 7'(i_additive_latency) + 7'(i_parity_latency) + 7'(cwl_cyc);
    wr_d.crc_mask_write_cmd_latency = i_crc_dm_en ?
      (`MRCFG_WCL_BASE + {1'b0, mr3_q[10:9]}) : 3'h0;
    wr_d.burst_ui = mr2_q[12] ? `MRCFG_CRC_UI : `MRCFG_STD_UI;
    odt_rsv_d = mr2_q[11] && (mr2_q[10:9] != 2'h0);
    dyn_d = i_write_active && !i_wr_level && mr2_q[11:9] != 3'h0 && !odt_rsv_d;
    wr_d.termination = dyn_d ? mr2_q[11:9] : 3'h0;
    mr3f_d.mpr_fmt = mr3_q[12:11];
    mr3f_d.wcl_code = mr3_q[10:9];
    mr3f_d.fgr = mr3_q[8:6];
    fgr_rsv_d = (mr3_q[8:6] == 3'h3) || (mr3_q[8:6] == 3'h4) || (mr3_q[8:6] == 3'h7);
    mr3f_d.temp_sense = mr3_q[5];
    mr3f_d.per_dev = mr3_q[4];
    mr3f_d.gear_down = mr3_q[3];
    mr3f_d.mpr_en = mr3_q[2];
    mr3f_d.mpr_page = mr3_q[1:0];
    redir_d = mr3_q[2] && i_read_cmd;
  end

  // Registering the decode adds one cycle after the shadow update.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      o_wr <= '0;
      o_wr_odt_dyn <= 1'b0;
      o_self_refresh_temp_range <= 2'h0;
      o_crc_en <= 1'b0;
      o_mr3 <= '0;
      o_fgr_reserved <= 1'b0;
      o_odt_reserved <= 1'b0;
      o_read_redirect <= 1'b0;
    end
    else
    begin
      o_wr <= wr_d;
      o_wr_odt_dyn <= dyn_d;
      o_self_refresh_temp_range <= mr2_q[7:6];
      o_crc_en <= mr2_q[12];
      o_mr3 <= mr3f_d;
      o_fgr_reserved <= fgr_rsv_d;
      o_odt_reserved <= odt_rsv_d;
      o_read_redirect <= redir_d;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  mrs_mr3_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mrs_hit && sel == `MRCFG_SEL_MR3 |=> mr3_q == $past(i_addr))
    else $error("register 3 not loaded");
  mr2_untouched_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(mrs_hit && sel == `MRCFG_SEL_MR2) |=> mr2_q == $past(mr2_q))
    else $error("register 2 changed without set");
  strobe_high_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_cmd_valid && i_ras_n |=> $stable(mr3_q) && $stable(mr2_q))
    else $error("set taken with strobe high");
  pre2_invalid_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_pre2 && !mr2_q[5] |=> !o_wr.lat_valid)
    else $error("low code valid with long preamble");
  cwl_16_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mr2_q[5:3] == 3'h5 |=> o_wr.write_data_latency == 5'h10)
    else $error("code 101 not 16");
  wl_sum_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_wr.total_write_latency == 7'($past(i_additive_latency))
      + 7'($past(i_parity_latency)) + 7'(o_wr.write_data_latency))
    else $error("total latency wrong");
  level_nom_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_wr_level |=> !o_wr_odt_dyn)
    else $error("dynamic termination in leveling");
  crc_burst_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mr2_q[12] |=> o_wr.burst_ui == `MRCFG_CRC_UI)
    else $error("crc burst not ten");
  redirect_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mr3_q[2] && i_read_cmd |=> o_read_redirect)
    else $error("read not redirected");
  gear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_mr3.gear_down == $past(mr3_q[3]))
    else $error("gear-down not followed");

  cwl_20_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mr2_q[5:3] == 3'h7 |=> o_wr.write_data_latency == 5'h14)
    else $error("code 111 not 20");

  pre2_14_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_pre2 && mr2_q[5:3] == 3'h4 |=> o_wr.lat_valid && o_wr.write_data_latency == 5'h0E)
    else $error("long preamble code 100 not 14");

  dyn_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_write_active && !i_wr_level && mr2_q[11:9] == 3'h1 |=> o_wr_odt_dyn
      && o_wr.termination == 3'h1)
    else $error("write termination not applied");

  fmt_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_mr3.mpr_fmt == $past(mr3_q[12:11]))
    else $error("readout format not followed");

  wcl_five_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_crc_dm_en && mr3_q[10:9] == 2'h1 |=> o_wr.crc_mask_write_cmd_latency == 3'h5)
    else $error("extra write latency not five");

  fgr_rsv_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mr3_q[8:6] == 3'h3 || mr3_q[8:6] == 3'h4 || mr3_q[8:6] == 3'h7 |=> o_fgr_reserved)
    else $error("reserved refresh code not flagged");

  temp_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_mr3.temp_sense == $past(mr3_q[5]))
    else $error("temperature status enable not followed");

  per_dev_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_mr3.per_dev == $past(mr3_q[4]))
    else $error("per-device mode not followed");

  mpr_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_mr3.mpr_en == $past(mr3_q[2]))
    else $error("readout routing not followed");

  page_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_mr3.mpr_page == $past(mr3_q[1:0]))
    else $error("readout page not followed");

  sr_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    1'b1 |=> o_self_refresh_temp_range == $past(mr2_q[7:6]))
    else $error("self-refresh range not followed");

  odt_rsv_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    mr2_q[11] && mr2_q[10:9] != 2'h0 |=> o_odt_reserved && !o_wr_odt_dyn)
    else $error("reserved termination code applied");

  // Main scenarios that the bench is expected to reach.
  cov_mr3_c: cover property (@(posedge i_ref_clk) mrs_hit && sel == `MRCFG_SEL_MR3);
  cov_crc_c: cover property (@(posedge i_ref_clk) o_crc_en);
  cov_dyn_c: cover property (@(posedge i_ref_clk) o_wr_odt_dyn);
  cov_redir_c: cover property (@(posedge i_ref_clk) o_read_redirect);
endmodule

// ===== verif/mrcfg_ctrl_model.sv
// Behavioural controller that issues mode register set commands.
`timescale 1ns/100ps
module mrcfg_ctrl_model
(
  // Clock.
  input wire logic i_clk,
  // Command and address bus.
  output logic o_cmd_valid,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [21:0] o_addr
);
  // The bus starts idle with all strobes high.
  initial
  begin
    o_cmd_valid = 1'b0;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    o_addr = 22'h000000;
  end
  // reserved zero, select
  // Reserved bits are cleared and the select field placed; strobes come from the caller.
  task automatic mrs(input logic [2:0] sel, input logic [21:0] val, input logic [2:0] stb);
    logic [21:0] mask;
    mask = (sel == 3'h2) ? 22'h3E2107 : 22'h3E2000;
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    {o_ras_n, o_cas_n, o_we_n} <= stb;
    o_addr <= (val & ~mask) | {1'b0, sel, 18'h00000};
  endtask
  // A released address shows the inverse, so a stale word can never look valid.
  task automatic idle();
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    {o_ras_n, o_cas_n, o_we_n} <= 3'h7;
    o_addr <= ~o_addr;
  endtask
endmodule

// ===== verif/test_sdram_mr2_mr3_config_decode.sv
// Self-checking bench for the mode register decode block.
`timescale 1ns/100ps
module test_sdram_mr2_mr3_config_decode;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pre2 = 1'b0, wr_act = 1'b0, wr_lvl = 1'b0, rd = 1'b0, crc_dm = 1'b0;
  logic [4:0] al = 5'h03;
  logic [4:0] pl = 5'h01;
  logic cv, ras_n, cas_n, we_n, odt_dyn, crc_en, fgr_rsv, odt_rsv, redir;
  logic [21:0] addr;
  logic [1:0] srt;
  logic [12:0] v;
  mrcfg_pkg::mrcfg_wr_t wr;
  mrcfg_pkg::mrcfg_mr3_t mr3;
  int error_cnt = 0;
  int n_compared = 0;
  int cwl [16] = '{9, 10, 11, 12, 14, 16, 18, 20, 0, 0, 0, 0, 14, 16, 18, 20};
  // Clock at 25 ns period.
  always #12.5 clk = ~clk;
  mrcfg_ctrl_model u_ctrl (.i_clk(clk), .o_cmd_valid(cv), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_addr(addr));
  mrcfg_top u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_cmd_valid(cv), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_addr(addr), .i_pre2(pre2), .i_write_active(wr_act),
    .i_wr_level(wr_lvl), .i_read_cmd(rd), .i_crc_dm_en(crc_dm), .i_additive_latency(al),
    .i_parity_latency(pl), .o_wr(wr), .o_wr_odt_dyn(odt_dyn), .o_self_refresh_temp_range(srt),
    .o_crc_en(crc_en), .o_mr3(mr3), .o_fgr_reserved(fgr_rsv), .o_odt_reserved(odt_rsv),
    .o_read_redirect(redir));
  // Case equality keeps an unknown from passing as a match.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic set_mr(input logic [2:0] sel, input logic [21:0] val);
    u_ctrl.mrs(sel, val, 3'h0);
    u_ctrl.idle();
    settle();
  endtask
  task automatic set_ctx(input logic p, input logic w, input logic l, input logic c);
    @(posedge clk);
    pre2 <= p;
    wr_act <= w;
    wr_lvl <= l;
    crc_dm <= c;
    settle();
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("mr3_rst", 32'h0, mr3);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 8; c++)
      begin
        set_ctx(p[0], 1'b0, 1'b0, 1'b0);
        set_mr(3'h2, {16'h0000, c[2:0], 3'h0});
        chk("lat_valid", !(p == 1 && c < 4), wr.lat_valid);
        if (!(p == 1 && c < 4))
        begin
          chk("cwl", cwl[p * 8 + c], wr.write_data_latency);
          chk("total_wl", al + pl + cwl[p * 8 + c], wr.total_write_latency);
        end
      end
    for (int t = 0; t < 8; t++)
    begin
      set_ctx(1'b0, 1'b1, 1'b0, 1'b0);
      set_mr(3'h2, {9'h000, t[0], t[2:0], 1'b0, t[1:0], 3'h4, 3'h0});
      chk("odt_dyn", (t >= 1 && t <= 4), odt_dyn);
      chk("odt_rsv", t > 4, odt_rsv);
      chk("termination", (t >= 1 && t <= 4) ? t : 0, wr.termination);
      chk("sr_temp", t[1:0], srt);
      chk("crc_en", t[0], crc_en);
      chk("burst_ui", t[0] ? 10 : 8, wr.burst_ui);
      set_ctx(1'b0, 1'b1, 1'b1, 1'b0);
      chk("odt_lvl", 0, odt_dyn);
      chk("term_lvl", 0, wr.termination);
    end
    // page three and short codes avoided
    for (int k = 0; k < 8; k++)
    begin
      v = {k[1:0], k[1:0], k[2:0], k[0], k[1], k[2], k[0], k[1] ? 2'h2 : {1'b0, k[0]}};
      set_ctx(1'b0, 1'b0, 1'b0, 1'b1);
      set_mr(3'h3, {9'h000, v});
      chk("mr3", v, mr3);
      chk("fgr_rsv", (k == 3 || k == 4 || k == 7), fgr_rsv);
      chk("wcl", 4 + k[1:0], wr.crc_mask_write_cmd_latency);
      @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("redirect", k[0], redir);
    end
    // Refused commands: wrong select, strobes not all low; then an accepted register 2 write.
    u_ctrl.mrs(3'h4, 22'h001555, 3'h0);
    u_ctrl.mrs(3'h3, 22'h001555, 3'h1);
    u_ctrl.mrs(3'h2, 22'h000028, 3'h0);
    u_ctrl.idle();
    settle();
    chk("mr3_hold", 13'h1FFE, mr3);
    chk("cwl_b2b", 16, wr.write_data_latency);
    complete_run();
  end
endmodule
